/* File: hw/flash_once_regs.vh */
// constants for the one-time field and program-phrase command sequencer
`ifndef FLASH_ONCE_REGS_VH
`define FLASH_ONCE_REGS_VH

// ***************************************************************
// command codes held in command object word 000, bits [15:8]
// ***************************************************************
`define CMD_READ_ONCE     8'h04
`define CMD_PROGRAM       8'h06
`define CMD_PROGRAM_ONCE  8'h07

// ***************************************************************
// command object indexes
// ***************************************************************
`define IX_CMD            3'h0
`define IX_ADDR           3'h1
`define IX_WORD0          3'h2
`define IX_WORD3          3'h5
`define IX_LAST           3'h5

// ***************************************************************
// field positions inside command object words
// ***************************************************************
`define CODE_MSB          15
`define CODE_LSB          8
`define GADDR_HI_MSB      1
`define GADDR_HI_LSB      0
`define ALIGN_MSB         2

// ***************************************************************
// one-time field size, phrase index range and reset values
// ***************************************************************
`define ONCE_BYTES        64
`define ONCE_PHRASES      8
`define ONCE_IX_MAX       16'h0007
`define ERASED_PHRASE     64'hffffffffffffffff
`define RST_INDEX         3'h0
`define RST_WORD          16'h0000
`define RST_COMMAND_COMPLETE_FLAG          1'b1

`endif

/* File: hw/flash_once_seq.v */
// command sequencer for read-once, program-phrase and program-once commands
`timescale 1ns/1ps
// Summary of operation
// R1 - a 64-byte one-time field of 8 phrases lives in the information area
// R2 - read-once uses code 04; index not 001 at launch raises access error
// R3 - read-once fetches the phrase into words 010..101, then sets complete
// R4 - one-time commands accept phrase index 0..7 only, else access error
// R5 - program-flash reads give invalid data while read-once runs
// R6 - read-once fetch errors set verify/uncorrectable flags, never protection
// R7 - any of the three commands not allowed in this mode sets access error
// R8 - software loads code 06, address high, address low, four data words
// R9 - program-phrase writes four words then reads back to verify
// R10 - program commands need index 101 at launch, else access error
// R11 - invalid or misaligned program address sets access error
// R12 - program address in protected region sets protection violation
// R13 - verify step errors set verify and uncorrectable flags
// R14 - software programs only erased phrases, never cumulatively
// R15 - software loads code 07, phrase index, four words for program-once
// R16 - program-once checks phrase erased, then programs and verifies
// R17 - program-once on an already programmed phrase sets access error
// R18 - a phrase previously programmed to all ones may be programmed again
// R19 - program-flash reads give invalid data while program-once runs
// R20 - software must not run one-time commands from the owning flash block
// R21 - software issues program-once only once per phrase
// R22 - software clears access and protection flags before a new command
// R23 - command words sit in an indexed set; last index is checked at launch
`include "flash_once_regs.vh"

module flash_once_seq
#(
  parameter [17:0] PFLASH_BASE = 18'h20000,  // lowest valid program-flash address
  parameter [17:0] PFLASH_LAST = 18'h3ffff   // highest valid program-flash address
)
(
  // clock and reset
  input  wire        sys_clk,
  input  wire        rst,
  // command object access
  input  wire        index_write,
  input  wire [2:0]  index_wdata,
  input  wire        word_write,
  input  wire [15:0] word_wdata,
  output reg  [2:0]  command_object_index,
  output reg  [15:0] command_object_word,
  // launch and status
  input  wire        launch,
  input  wire        clear_access_error,
  input  wire        clear_protection_violation,
  input  wire        mode_permits,
  input  wire [17:0] protect_lo,
  input  wire [17:0] protect_hi,
  output reg         command_complete_flag,
  output reg         access_error_flag,
  output reg         protection_violation_flag,
  output reg         verify_error_flag,
  output reg         uncorrectable_error_flag,
  output wire        pflash_read_invalid,
  // flash array port
  output reg         nvm_req,
  output reg         nvm_write,
  output reg         nvm_once,
  output reg  [17:0] nvm_addr,
  output reg  [63:0] nvm_wdata,
  input  wire        nvm_ack,
  input  wire [63:0] nvm_rdata,
  input  wire        nvm_err,
  input  wire        nvm_uncorr
);

  // ***************************************************************
  // states
  // ***************************************************************
  localparam [4:0] S_IDLE   = 5'b00001;
  localparam [4:0] S_FETCH  = 5'b00010;  // read-once fetch or erased check
  localparam [4:0] S_PROG   = 5'b00100;
  localparam [4:0] S_VERIFY = 5'b01000;
  localparam [4:0] S_DONE   = 5'b10000;

  reg  [4:0]  state;
  reg  [4:0]  next_state;
  reg  [7:0]  cmd;
  reg  [15:0] cob [0:5];
  reg         launch_err;
  reg         launch_pv;
  integer     i;

  wire [7:0]  code      = cob[`IX_CMD][`CODE_MSB:`CODE_LSB];
  wire [17:0] gaddr     = {cob[`IX_CMD][`GADDR_HI_MSB:`GADDR_HI_LSB], cob[`IX_ADDR]};
  wire [63:0] data_word = {cob[5], cob[4], cob[3], cob[2]};
  wire        once_cmd  = (cmd == `CMD_READ_ONCE) || (cmd == `CMD_PROGRAM_ONCE);
  wire        busy      = !command_complete_flag;
  wire        start     = launch && !busy && !access_error_flag
                          && !protection_violation_flag;
  wire        done_now  = (state == S_DONE);

  // phrase index check shared by both one-time commands
  function idx_ok;
    input [15:0] ix;
    begin
      idx_ok = (ix <= `ONCE_IX_MAX); // R4
    end
  endfunction

  // one-time field address from phrase index, 8 bytes per phrase
  function [17:0] once_addr;
    input [15:0] ix;
    begin
      once_addr = {12'h000, ix[2:0], 3'h0}; // R1
    end
  endfunction

  // ***************************************************************
  // launch checks
  // ***************************************************************
  // refusal decided in one cycle, so the flag stands before anything runs
  always @*
  begin
    launch_err = 1'b0;
    launch_pv  = 1'b0;
    case (code)
      `CMD_READ_ONCE:
      begin
        if (command_object_index != `IX_ADDR) // R2 R23
          launch_err = 1'b1;
        if (!idx_ok(cob[`IX_ADDR])) // R4
          launch_err = 1'b1;
      end
      `CMD_PROGRAM:
      begin
        if (command_object_index != `IX_LAST) // R10 R23
          launch_err = 1'b1;
        if (gaddr < PFLASH_BASE || gaddr > PFLASH_LAST) // R11
          launch_err = 1'b1;
        if (gaddr[`ALIGN_MSB:0] != 3'h0) // R11
          launch_err = 1'b1;
        if (gaddr >= protect_lo && gaddr <= protect_hi) // R12
          launch_pv = 1'b1;
      end
      `CMD_PROGRAM_ONCE:
      begin
        if (command_object_index != `IX_LAST) // R10 R23
          launch_err = 1'b1;
        if (!idx_ok(cob[`IX_ADDR])) // R4
          launch_err = 1'b1;
      end
      default: launch_err = 1'b1;  // unknown command
    endcase
    if (!mode_permits) // R7
      launch_err = 1'b1;
  end

  // ***************************************************************
  // sequencer
  // ***************************************************************
  // next state; a refused launch stays idle
  always @*
  begin
    next_state = state;
    case (state)
      S_IDLE:
      begin
        if (start && !launch_err && !launch_pv)
        begin
          if (code == `CMD_PROGRAM)
            next_state = S_PROG; // R9
          else
            next_state = S_FETCH; // R3 R16
        end
      end
      S_FETCH:
      begin
        if (nvm_ack)
        begin
          if (cmd == `CMD_READ_ONCE)
            next_state = S_DONE; // R3
          else if (nvm_rdata == `ERASED_PHRASE)
            next_state = S_PROG; // R16 R18
          else
            next_state = S_DONE; // R17
        end
      end
      S_PROG:
      begin
        if (nvm_ack)
          next_state = S_VERIFY; // R9 R16
      end
      S_VERIFY:
      begin
        if (nvm_ack)
          next_state = S_DONE;
      end
      S_DONE:   next_state = S_IDLE;
      default:  next_state = S_IDLE;
    endcase
  end

  always @(posedge sys_clk)
  begin
    if (rst)
      state <= S_IDLE;
    else
      state <= next_state;
  end

  // latch command at launch so later word writes cannot change it
  always @(posedge sys_clk)
  begin
    if (rst)
      cmd <= 8'h00;
    else if (start)
      cmd <= code;
  end

  // flash array requests, held until the array acknowledges
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      nvm_req   <= 1'b0;
      nvm_write <= 1'b0;
      nvm_once  <= 1'b0;
      nvm_addr  <= 18'h00000;
      nvm_wdata <= 64'h0000000000000000;
    end
    else
    begin
      if (nvm_ack)
        nvm_req <= 1'b0;
      if (state == S_IDLE && next_state != S_IDLE)
      begin
        nvm_req   <= 1'b1;
        nvm_write <= (next_state == S_PROG);
        nvm_once  <= (code != `CMD_PROGRAM); // R1
        nvm_addr  <= (code == `CMD_PROGRAM) ? gaddr : once_addr(cob[`IX_ADDR]);
        nvm_wdata <= data_word;
      end
      else if (nvm_ack && next_state == S_PROG)
      begin
        nvm_req   <= 1'b1; // R16
        nvm_write <= 1'b1;
      end
      else if (nvm_ack && next_state == S_VERIFY)
      begin
        nvm_req   <= 1'b1; // R9
        nvm_write <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // command object words and index
  // ***************************************************************
  // writes while a command runs are dropped to keep the operands stable
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      command_object_index <= `RST_INDEX;
      for (i = 0; i < 6; i = i + 1)
        cob[i] <= `RST_WORD;
    end
    else
    begin
      if (index_write && !busy)
        command_object_index <= index_wdata; // R23
      if (word_write && !busy && command_object_index <= `IX_LAST)
        cob[command_object_index] <= word_wdata; // R23
      if (state == S_FETCH && nvm_ack && cmd == `CMD_READ_ONCE)
      begin
        cob[2] <= nvm_rdata[15:0]; // R3
        cob[3] <= nvm_rdata[31:16];
        cob[4] <= nvm_rdata[47:32];
        cob[5] <= nvm_rdata[63:48];
      end
    end
  end

  // read-back of the selected word; indexes above 101 read as zero
  always @(posedge sys_clk)
  begin
    if (rst)
      command_object_word <= `RST_WORD;
    else if (command_object_index <= `IX_LAST)
      command_object_word <= cob[command_object_index];
    else
      command_object_word <= `RST_WORD;
  end

  // ***************************************************************
  // status flags
  // ***************************************************************
  // access and protection flags are sticky, verify and uncorrectable flags clear at launch; a set in the clear cycle wins
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      command_complete_flag     <= `RST_COMMAND_COMPLETE_FLAG;
      access_error_flag         <= 1'b0;
      protection_violation_flag <= 1'b0;
      verify_error_flag         <= 1'b0;
      uncorrectable_error_flag  <= 1'b0;
    end
    else
    begin
      if (clear_access_error)
        access_error_flag <= 1'b0;
      if (clear_protection_violation)
        protection_violation_flag <= 1'b0;
      if (start)
      begin
        verify_error_flag        <= 1'b0;
        uncorrectable_error_flag <= 1'b0;
        if (launch_err)
          access_error_flag <= 1'b1; // R2 R4 R7 R10 R11
        else if (launch_pv)
          protection_violation_flag <= 1'b1; // R12
        else
          command_complete_flag <= 1'b0; // R16
      end
      // read-once fetch errors; protection flag is never touched here
      if (state == S_FETCH && nvm_ack && cmd == `CMD_READ_ONCE)
      begin
        if (nvm_err)
          verify_error_flag <= 1'b1; // R6
        if (nvm_uncorr)
          uncorrectable_error_flag <= 1'b1; // R6
      end
      // program-once target already holds data other than all ones
      if (state == S_FETCH && nvm_ack && cmd == `CMD_PROGRAM_ONCE
          && nvm_rdata != `ERASED_PHRASE)
        access_error_flag <= 1'b1; // R17
      // verify read-back compares against what was written
      if (state == S_VERIFY && nvm_ack)
      begin
        if (nvm_err || nvm_rdata != nvm_wdata)
          verify_error_flag <= 1'b1; // R13
        if (nvm_uncorr)
          uncorrectable_error_flag <= 1'b1; // R13
      end
      if (done_now)
        command_complete_flag <= 1'b1; // R3 R9 R16
    end
  end

  // cpu reads of program flash are poisoned while a one-time command runs
  assign pflash_read_invalid = busy && once_cmd; // R5 R19

endmodule // flash_once_seq

/* File: verification/flash_once_checker.sv */
// assertion checker for the one-time field command sequencer
`timescale 1ns/1ps
module flash_once_checker
(
  // clock and reset
  input wire        sys_clk,
  input wire        rst,
  // launch side
  input wire        launch,
  input wire        mode_permits,
  input wire        command_complete_flag,
  input wire        access_error_flag,
  input wire        protection_violation_flag,
  input wire        pflash_read_invalid,
  // array side
  input wire        nvm_req,
  input wire        nvm_once,
  input wire [17:0] nvm_addr,
  input wire        nvm_ack
);
  // ************************************************
  // properties
  // ************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // a launch that meets an idle sequencer with no pending flag
  sequence s_take;
    launch && command_complete_flag && !access_error_flag && !protection_violation_flag;
  endsequence
  sequence s_take_ok;
    s_take ##0 mode_permits;
  endsequence
  a_mode_refuse: assert property (s_take ##0 !mode_permits |=>
    access_error_flag && command_complete_flag) else $error("mode refusal missing");
  a_take_start: assert property (s_take_ok |=> (!command_complete_flag && nvm_req)
    || access_error_flag || protection_violation_flag) else $error("launch not taken");
  a_start_cause: assert property ($fell(command_complete_flag) |->
    $past(launch) && $past(mode_permits)) else $error("busy without launch");
  a_done_delay: assert property ($rose(command_complete_flag) |->
    $past(nvm_ack, 2)) else $error("complete not two edges after ack");
  a_req_hold: assert property (nvm_req && !nvm_ack |=>
    nvm_req && $stable(nvm_addr)) else $error("request dropped early");
  a_read_invalid: assert property (nvm_req && nvm_once |->
    pflash_read_invalid && !command_complete_flag) else $error("reads not invalid");
  a_invalid_busy: assert property (pflash_read_invalid ==
    (!command_complete_flag && nvm_once)) else $error("invalid flag wrong");
  a_once_range: assert property (nvm_req && nvm_once |->
    nvm_addr[2:0] == 3'h0 && nvm_addr < 18'h40) else $error("one-time address bad");
  a_prog_align: assert property (nvm_req && !nvm_once |->
    nvm_addr[2:0] == 3'h0) else $error("program address misaligned");
  a_once_noprot: assert property (nvm_once && !command_complete_flag |=>
    !$rose(protection_violation_flag)) else $error("protection set by one-time");
endmodule // flash_once_checker

bind flash_once_seq flash_once_checker flash_once_checker_i (.sys_clk(sys_clk), .rst(rst),
  .launch(launch), .mode_permits(mode_permits), .command_complete_flag(command_complete_flag),
  .access_error_flag(access_error_flag), .pflash_read_invalid(pflash_read_invalid),
  .protection_violation_flag(protection_violation_flag), .nvm_req(nvm_req),
  .nvm_once(nvm_once), .nvm_addr(nvm_addr), .nvm_ack(nvm_ack));

/* File: verification/tb_top.sv */
// self-checking bench for the one-time field command sequencer
`timescale 1ns/1ps
module tb_top;
  // ************************************************
  // signals, design and array model
  // ************************************************
  reg         sys_clk, rst, ixw, ww, launch, clr_ae, clr_pv, mode_ok, ack, err, unc;
  reg  [2:0]  ixd, wait_n;
  reg  [15:0] wd, cur_word;
  reg  [1:0]  inj;
  reg  [63:0] rdata, main_mem;
  reg  [63:0] once_mem [0:7];
  wire [2:0]  cur_ix;
  wire [15:0] word_out;
  wire        ccf, ae, pv, ve, ue, req, wr, once, inv;
  wire [17:0] addr;
  wire [63:0] wdata;
  integer     miscompares, n_checks, cycles, i;
  localparam [63:0] D1 = 64'h0123456789abcdef;
  localparam [63:0] D2 = 64'hfedc0000a5a51234;

  flash_once_seq flash_once_seq_i (.sys_clk(sys_clk), .rst(rst), .index_write(ixw),
    .index_wdata(ixd), .word_write(ww), .word_wdata(wd), .command_object_index(cur_ix),
    .command_object_word(word_out), .launch(launch), .clear_access_error(clr_ae),
    .clear_protection_violation(clr_pv), .mode_permits(mode_ok), .protect_lo(18'h30000),
    .protect_hi(18'h300ff), .command_complete_flag(ccf), .access_error_flag(ae),
    .protection_violation_flag(pv), .verify_error_flag(ve), .uncorrectable_error_flag(ue),
    .pflash_read_invalid(inv), .nvm_req(req), .nvm_write(wr), .nvm_once(once),
    .nvm_addr(addr), .nvm_wdata(wdata), .nvm_ack(ack), .nvm_rdata(rdata),
    .nvm_err(err), .nvm_uncorr(unc));

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ceiling far above what the scenarios take, so only a hang reaches it
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      miscompares = miscompares + 1;
      $display("BAD %0t timeout", $time);
      finish_test;
    end
  end

  // array answers after four cycles; released data toggles so stale values never match
  always @(posedge sys_clk)
  begin
    ack <= 1'b0;
    rdata <= ~rdata;
    if (req && !ack)
    begin
      wait_n <= wait_n + 3'h1;
      if (wait_n == 3'h3)
      begin
        wait_n <= 3'h0;
        ack <= 1'b1;
        err <= inj[0];
        unc <= inj[1];
        rdata <= once ? once_mem[addr[5:3]] : main_mem ^ {63'h0, inj[0]};
        if (wr && once) once_mem[addr[5:3]] <= wdata;
        if (wr && !once) main_mem <= wdata;
      end
    end
  end

  task chk(input [63:0] got, input [63:0] exp);
  begin
    n_checks = n_checks + 1;
    if (got !== exp)
    begin
      miscompares = miscompares + 1;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  end
  endtask

  // select an index, then optionally write the word there
  task put(input [2:0] ix, input [15:0] d, input w);
  begin
    @(posedge sys_clk);
    ixw <= 1'b1;
    ixd <= ix;
    @(posedge sys_clk);
    ixw <= 1'b0;
    ww <= w;
    wd <= d;
    @(posedge sys_clk);
    ww <= 1'b0;
  end
  endtask

  // load words, leave index li, launch, wait bounded, compare {ccf,ae,pv,ve,ue}
  task cmd(input [15:0] w0, input [15:0] w1, input [63:0] d, input [2:0] li,
           input [4:0] st);
    integer k;
  begin
    put(3'h0, w0, 1'b1);
    put(3'h1, w1, 1'b1);
    for (k = 0; k < 4; k = k + 1)
      put(k[2:0] + 3'h2, d[16*k +: 16], 1'b1);
    put(li, 16'h0, 1'b0);
    @(posedge sys_clk);
    launch <= 1'b1;
    @(posedge sys_clk);
    launch <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 chk(inv, !ccf && w0[15:8] != 8'h06);
    for (k = 0; k < 200 && ccf !== 1'b1; k = k + 1)
      @(posedge sys_clk);
    #1 chk({ccf, ae, pv, ve, ue}, st);
  end
  endtask

  // pending flags block the next launch, so drop them
  task clr;
  begin
    @(posedge sys_clk);
    clr_ae <= 1'b1;
    clr_pv <= 1'b1;
    @(posedge sys_clk);
    clr_ae <= 1'b0;
    clr_pv <= 1'b0;
  end
  endtask

  task finish_test;
  begin
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask

  // ************************************************
  // main sequence
  // ************************************************
  initial
  begin
    {rst, mode_ok} = 2'b11;
    {ixw, ww, launch, clr_ae, clr_pv, ack, err, unc, ixd, wait_n, wd, inj} = 0;
    {rdata, main_mem, miscompares, n_checks, cycles} = 0;
    for (i = 0; i < 8; i = i + 1)
      once_mem[i] = 64'hffffffffffffffff;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    #1 chk({ccf, ae, pv, ve, ue, cur_ix, word_out}, {5'h10, 19'h0});
    put(3'h2, 16'h1234, 1'b1);
    put(3'h2, 16'h0, 1'b0);
    #1 chk(word_out, 16'h1234);
    cmd(16'h0400, 16'h0001, 64'h0, 3'h0, 5'h18);
    clr;
    @(posedge sys_clk) mode_ok <= 1'b0;
    cmd(16'h0400, 16'h0001, 64'h0, 3'h1, 5'h18);
    clr;
    @(posedge sys_clk) mode_ok <= 1'b1;
    cmd(16'h0400, 16'h0008, 64'h0, 3'h1, 5'h18);
    clr;
    cmd(16'h0500, 16'h0001, 64'h0, 3'h1, 5'h18);
    clr;
    cmd(16'h0700, 16'h0003, D1, 3'h5, 5'h10);
    chk(once_mem[3], D1);
    cmd(16'h0400, 16'h0003, 64'h0, 3'h1, 5'h10);
    for (i = 0; i < 4; i = i + 1)
    begin
      put(i[2:0] + 3'h2, 16'h0, 1'b0);
      #1 chk(word_out, D1[16*i +: 16]);
    end
    cmd(16'h0700, 16'h0003, 64'h0, 3'h5, 5'h18);
    clr;
    chk(once_mem[3], D1);
    cmd(16'h0700, 16'h0009, D2, 3'h5, 5'h18);
    clr;
    cmd(16'h0700, 16'h0004, 64'hffffffffffffffff, 3'h5, 5'h10);
    cmd(16'h0700, 16'h0004, D2, 3'h5, 5'h10);
    chk(once_mem[4], D2);
    cmd(16'h0602, 16'h0008, D2, 3'h5, 5'h10);
    chk(main_mem, D2);
    cmd(16'h0602, 16'h0004, D2, 3'h5, 5'h18);
    clr;
    cmd(16'h0600, 16'h0008, D2, 3'h5, 5'h18);
    clr;
    cmd(16'h0602, 16'h0008, D2, 3'h4, 5'h18);
    clr;
    cmd(16'h0603, 16'h0010, D2, 3'h5, 5'h14);
    clr;
    inj = 2'b01;
    cmd(16'h0602, 16'h0010, D1, 3'h5, 5'h12);
    inj = 2'b11;
    cmd(16'h0400, 16'h0003, 64'h0, 3'h1, 5'h13);
    inj = 2'b00;
    finish_test;
  end
endmodule // tb_top
